// File: src/xskip_pkg.sv
/*
  Shared constants and operation codes for the extended skip, table-read and
  exclusive-or execution unit.
  Assumes an 8-bit data path and a 16-bit program word.
*/
package xskip_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PADDR_W = 16;
  localparam int unsigned PWORD_W = 16;

  // ==========================================================================
  // Reset values and fixed byte constants
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TPL_RST = 8'h00;
  localparam logic [7:0] TPH_RST = 8'h00;
  localparam logic [7:0] TBH_RST = 8'h00;
  localparam logic [7:0] LAST_PAGE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Operations handed over by the decoder
  typedef enum logic [3:0] {
    op_none,
    skip_on_null_byte,
    copy_then_skip_on_null,
    skip_on_null_bit,
    table_read_current_page,
    table_read_last_page,
    incr_table_read,
    incr_table_read_last_page,
    exclusive_or_to_accumulator,
    exclusive_or_to_memory
  } op_t;
endpackage : xskip_pkg

// File: src/xskip_exec.sv
/*
  Execution unit for the extended skip, table-read and exclusive-or group.
  Assumes: the fetch stage presents one decoded operation per instruction
  cycle with op_valid, together with the memory byte already read; program
  memory answers a table address in the same cycle (combinational port).
*/
`timescale 1ns/1ps
`default_nettype none
module xskip_exec
  import xskip_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                op_valid,
  input  wire xskip_pkg::op_t      op,
  input  wire logic [2:0]          bit_sel,
  input  wire logic [7:0]          mem_rdata,
  input  wire logic [7:0]          cur_page,
  input  wire logic [15:0]         prog_rdata,
  output logic      [15:0]         prog_addr,
  output logic                     mem_we,
  output logic      [7:0]          mem_wdata,
  output logic      [7:0]          accumulator,
  output logic                     zero_flag,
  output logic      [7:0]          table_pointer_low,
  output logic      [7:0]          table_pointer_high,
  output logic      [7:0]          table_high_byte_reg,
  output logic                     skip_nop
);
  import xskip_pkg::*;

  // ==========================================================================
  // Decode of the current cycle
  logic       exec;
  logic       is_skip;
  logic       skip_cond;
  logic [7:0] tpl_inc;
  logic [7:0] tpl_use;
  logic [7:0] page_use;
  logic [7:0] xor_res;
  logic       is_tab;

  // Squashed slot changes no state except prog_addr, which loads every cycle
  assign exec    = op_valid && !skip_nop;
  assign xor_res = accumulator ^ mem_rdata;
  assign tpl_inc = table_pointer_low + 8'h01;

  always_comb
  begin
    is_skip   = 1'b0;
    skip_cond = 1'b0;
    is_tab    = 1'b0;
    tpl_use   = table_pointer_low;
    page_use  = cur_page;
    case (op)
      skip_on_null_byte, copy_then_skip_on_null:
      begin
        is_skip   = 1'b1;
        skip_cond = (mem_rdata == ZERO_BYTE);
      end
      skip_on_null_bit:
      begin
        is_skip   = 1'b1;
        skip_cond = !mem_rdata[bit_sel];
      end
      table_read_current_page:
        is_tab = 1'b1;
      table_read_last_page:
      begin
        is_tab   = 1'b1;
        page_use = LAST_PAGE;
      end
      incr_table_read:
      begin
        is_tab   = 1'b1;
        tpl_use  = tpl_inc;
        page_use = table_pointer_high;
      end
      incr_table_read_last_page:
      begin
        is_tab   = 1'b1;
        tpl_use  = tpl_inc;
        page_use = LAST_PAGE;
      end
      default:
      begin
        is_skip = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Skip: the already fetched follower becomes the dummy cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      skip_nop <= 1'b0;
    else
      skip_nop <= exec && is_skip && skip_cond;
  end

  // ==========================================================================
  // Program table address, registered toward program memory
  always_ff @(posedge clk)
  begin
    if (rst)
      prog_addr <= 16'h0000;
    else
      prog_addr <= {page_use, tpl_use};
  end

  // ==========================================================================
  // Table pointer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      table_pointer_low  <= TPL_RST;
      table_pointer_high <= TPH_RST;
    end
    else if (exec && (op == incr_table_read || op == incr_table_read_last_page))
      table_pointer_low <= tpl_inc;
  end

  // ==========================================================================
  // Memory write and table-high register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_we              <= 1'b0;
      mem_wdata           <= 8'h00;
      table_high_byte_reg <= TBH_RST;
    end
    else
    begin
      mem_we <= exec && (is_tab || op == exclusive_or_to_memory);
      if (exec && is_tab)
      begin
        mem_wdata           <= prog_rdata[7:0];
        table_high_byte_reg <= prog_rdata[15:8];
      end
      else if (exec && op == exclusive_or_to_memory)
        mem_wdata <= xor_res;
    end
  end

  // ==========================================================================
  // Accumulator and zero flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accumulator <= ACC_RST;
      zero_flag   <= 1'b0;
    end
    else if (exec)
    begin
      case (op)
        copy_then_skip_on_null:
          accumulator <= mem_rdata;
        exclusive_or_to_accumulator:
        begin
          accumulator <= xor_res;
          zero_flag   <= (xor_res == ZERO_BYTE);
        end
        exclusive_or_to_memory:
          zero_flag <= (xor_res == ZERO_BYTE);
        default:
          zero_flag <= zero_flag;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  skip_taken_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == skip_on_null_byte && mem_rdata == 8'h00 |=> skip_nop)
    else $error("zero byte did not skip");
  skip_single_a: assert property (@(posedge clk) disable iff (rst)
    skip_nop |=> !skip_nop)
    else $error("dummy cycle longer than one");
  copy_acc_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == copy_then_skip_on_null |=> accumulator == $past(mem_rdata)
    && zero_flag == $past(zero_flag))
    else $error("copy to accumulator wrong");
  bit_skip_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == skip_on_null_bit |=> skip_nop == !$past(mem_rdata[bit_sel]))
    else $error("bit skip wrong");
  tab_cur_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == table_read_current_page |=> mem_we
    && prog_addr == {$past(cur_page), $past(table_pointer_low)})
    else $error("current page read wrong");
  tab_last_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == table_read_last_page |=> prog_addr[15:8] == 8'hff)
    else $error("last page read wrong");
  tab_incr_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && (op == incr_table_read || op == incr_table_read_last_page)
    |=> table_pointer_low == $past(table_pointer_low) + 8'h01 && prog_addr[7:0] == table_pointer_low)
    else $error("pre-increment read wrong");
  tab_incl_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == incr_table_read_last_page |=> prog_addr[15:8] == 8'hff)
    else $error("pre-increment last page wrong");
  xor_acc_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == exclusive_or_to_accumulator
    |=> accumulator == ($past(accumulator) ^ $past(mem_rdata)) && zero_flag == (accumulator == 8'h00))
    else $error("xor to accumulator wrong");
  xor_mem_a: assert property (@(posedge clk) disable iff (rst)
    op_valid && !skip_nop && op == exclusive_or_to_memory
    |=> mem_we && mem_wdata == ($past(accumulator) ^ $past(mem_rdata)) && zero_flag == (mem_wdata == 8'h00))
    else $error("xor to memory wrong");
  squash_a: assert property (@(posedge clk) disable iff (rst)
    skip_nop |=> !mem_we && $stable(accumulator) && $stable(zero_flag) && $stable(table_pointer_low))
    else $error("skipped instruction had effect");
endmodule : xskip_exec
`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench for the skip, table-read and exclusive-or unit.
  Assumes the bench stands in for fetch, data memory and program memory.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import xskip_pkg::*;
  logic        clk, rst, op_valid, mem_we, zero_flag, skip_nop;
  op_t         op;
  logic [2:0]  bit_sel;
  logic [7:0]  mem_rdata, cur_page, mem_wdata, accumulator, tpl, tph, tbh, tpl_e;
  logic [15:0] prog_rdata, prog_addr, a;
  int          fails, check_count, cycles;

  xskip_exec xskip_exec_inst (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .bit_sel(bit_sel),
    .mem_rdata(mem_rdata), .cur_page(cur_page), .prog_rdata(prog_rdata), .prog_addr(prog_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .accumulator(accumulator), .zero_flag(zero_flag),
    .table_pointer_low(tpl), .table_pointer_high(tph), .table_high_byte_reg(tbh), .skip_nop(skip_nop));

  // ==========================================================================
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      final_report();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic final_report;
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  // Leaves op_valid high so back-to-back ops never toggle it in one step
  task automatic issue(input op_t o, input logic [7:0] m, input logic [2:0] b);
    op_valid = 1'b1;
    op = o;
    mem_rdata = m;
    bit_sel = b;
    @(posedge clk);
    #1;
  endtask : issue

  task automatic idle;
    op_valid = 1'b0;
    @(posedge clk);
    #1;
    chk("skip_nop", 16'(skip_nop), 16'h0000);
  endtask : idle

  // ==========================================================================
  // Scenarios
  task automatic t_copy_bits;
    for (int i = 0; i < 8; i++)
    begin
      issue(skip_on_null_bit, ~(8'h01 << i), i[2:0]);
      chk("skip_nop", 16'(skip_nop), 16'h0001);
      idle();
      issue(skip_on_null_bit, 8'h01 << i, i[2:0]);
      chk("skip_nop", 16'(skip_nop), 16'h0000);
      issue(copy_then_skip_on_null, 8'h80 >> i, 3'h0);
      chk("skip_nop", 16'(skip_nop), 16'h0000);
      chk("accumulator", 16'(accumulator), 16'(8'h80 >> i));
      issue(copy_then_skip_on_null, 8'h00, 3'h0);
      chk("skip_nop", 16'(skip_nop), 16'h0001);
      chk("zero_flag", 16'(zero_flag), 16'h0000);
      idle();
    end
  endtask : t_copy_bits

  task automatic t_xor;
    issue(copy_then_skip_on_null, 8'h3c, 3'h0);
    issue(exclusive_or_to_accumulator, 8'h3c, 3'h0);
    chk("accumulator", 16'(accumulator), 16'h0000);
    chk("zero_flag", 16'(zero_flag), 16'h0001);
    issue(exclusive_or_to_accumulator, 8'h81, 3'h0);
    chk("accumulator", 16'(accumulator), 16'h0081);
    chk("zero_flag", 16'(zero_flag), 16'h0000);
    issue(exclusive_or_to_memory, 8'h81, 3'h0);
    chk("mem_we", 16'(mem_we), 16'h0001);
    chk("mem_wdata", 16'(mem_wdata), 16'h0000);
    chk("zero_flag", 16'(zero_flag), 16'h0001);
    chk("accumulator", 16'(accumulator), 16'h0081);
  endtask : t_xor

  // Squashed op would turn the accumulator into 8'h7e
  task automatic t_skip;
    issue(skip_on_null_byte, 8'h00, 3'h0);
    chk("skip_nop", 16'(skip_nop), 16'h0001);
    issue(exclusive_or_to_accumulator, 8'hff, 3'h0);
    chk("accumulator", 16'(accumulator), 16'h0081);
    chk("skip_nop", 16'(skip_nop), 16'h0000);
    issue(skip_on_null_byte, 8'h01, 3'h0);
    chk("skip_nop", 16'(skip_nop), 16'h0000);
    issue(copy_then_skip_on_null, 8'h00, 3'h0);
    chk("skip_nop", 16'(skip_nop), 16'h0001);
    issue(incr_table_read, 8'h00, 3'h0);
    chk("mem_we", 16'(mem_we), 16'h0000);
    chk("table_pointer_low", 16'(tpl), 16'(TPL_RST));
  endtask : t_skip

  // Enough pre-increments to wrap the low pointer twice
  task automatic t_tab;
    op_t o;
    for (int j = 0; j < 600; j++)
    begin
      o = (j < 4) ? op_t'(4 + j) : op_t'(6 + j % 2);
      cur_page = j[7:0] ^ 8'h5a;
      if (o >= incr_table_read)
        tpl_e = tpl_e + 8'h01;
      a = (o == table_read_current_page) ? {cur_page, tpl_e} :
          (o == incr_table_read) ? {TPH_RST, tpl_e} : {LAST_PAGE, tpl_e};
      prog_rdata = a ^ 16'ha5c3;
      issue(o, 8'h00, 3'h0);
      chk("prog_addr", prog_addr, a);
      chk("mem_we", 16'(mem_we), 16'h0001);
      chk("mem_wdata", 16'(mem_wdata), 16'(prog_rdata[7:0]));
      chk("table_high_byte_reg", 16'(tbh), 16'(prog_rdata[15:8]));
      chk("table_pointer_low", 16'(tpl), 16'(tpl_e));
    end
    chk("table_pointer_high", 16'(tph), 16'(TPH_RST));
  endtask : t_tab

  initial
  begin
    rst = 1'b1;
    op_valid = 1'b0;
    op = op_none;
    bit_sel = 3'h0;
    mem_rdata = 8'h00;
    cur_page = 8'h00;
    prog_rdata = 16'h0000;
    tpl_e = TPL_RST;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("accumulator", 16'(accumulator), 16'(ACC_RST));
    chk("table_pointer_low", 16'(tpl), 16'(TPL_RST));
    t_copy_bits();
    t_xor();
    t_skip();
    t_tab();
    idle();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
